// ===== common/nibble_add_params.svh
// offsets, fields, reset values and opcodes of the nibble add datapath
`ifndef NIBBLE_ADD_PARAMS_SVH
`define NIBBLE_ADD_PARAMS_SVH

`define NA_OFS_CTRL      4'h0
`define NA_OFS_FLAGS     4'h1
`define NA_OFS_IDX_HIGH  4'h2
`define NA_OFS_IDX_MID   4'h3
`define NA_OFS_IDX_LOW   4'h4
`define NA_OFS_GP_HIGH   4'h5
`define NA_OFS_GP_LOW    4'h6
`define NA_OFS_STATUS    4'h7
`define NA_OFS_BANK      4'h8

`define NA_MEM_SEL_BIT   11

`define NA_CTRL_COMPARE  0
`define NA_CTRL_DEC      1
`define NA_CTRL_INDEX    2
`define NA_FLAGS_CARRY   0
`define NA_FLAGS_Z       1
`define NA_STAT_BUSY     4
`define NA_STAT_ILL      5

`define NA_CTRL_RST      3'h0
`define NA_FLAGS_RST     2'h0
`define NA_NIB_RST       4'h0

`define NA_OPC_HI        15
`define NA_OPC_LO        11
`define NA_ROW_HI        10
`define NA_ROW_LO        8
`define NA_COL_HI        7
`define NA_COL_LO        4
`define NA_IMM_HI        3
`define NA_IMM_LO        0

`define NA_OPC_ADD_IMM   5'h10
`define NA_OPC_CARRY_REG 5'h02
`define NA_OPC_CARRY_IMM 5'h12

`define NA_DEC_MAX       5'h09
`define NA_DEC_ADJ       5'h06

`endif

// ===== common/nibble_add_pkg.sv
// types shared by the nibble add datapath
package nibble_add_pkg;
	typedef enum logic [1:0] {
		op_add_imm,
		op_carry_reg,
		op_carry_imm,
		op_bad
	} op_t;

	typedef enum logic {
		st_idle,
		st_exec
	} state_t;

	typedef logic [9:0] mem_addr_t;
endpackage

// ===== src/nibble_adder.sv
// 4-bit binary or decimal adder with carry in and carry out
`timescale 1ns/1ps
`include "nibble_add_params.svh"

module nibble_adder (
	input  wire logic [3:0] a,
	input  wire logic [3:0] b,
	input  wire logic       cin,
	input  wire logic       decimal,
	output logic      [3:0] sum,
	output logic            cout
);
	wire logic [4:0] raw;
	wire logic [4:0] adj;
	wire logic       over;

	assign raw  = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	// a digit above nine is folded back by six; carry is the decimal carry
	assign over = decimal && (raw > `NA_DEC_MAX);
	assign adj  = raw + `NA_DEC_ADJ;
	assign sum  = over ? adj[3:0] : raw[3:0];
	assign cout = over ? 1'b1 : raw[4];
endmodule

// ===== src/addr_former.sv
// effective data memory address and general register address
`timescale 1ns/1ps

module addr_former (
	input  wire logic [2:0] bank,
	input  wire logic [2:0] row,
	input  wire logic [3:0] col,
	input  wire logic       index_enable,
	input  wire logic [2:0] index_pointer_high,
	input  wire logic [2:0] index_pointer_mid,
	input  wire logic [3:0] index_pointer_low,
	input  wire logic [2:0] gp_row_pointer_high,
	input  wire logic [2:0] gp_row_pointer_low,
	input  wire logic [3:0] reg_col,
	output logic      [9:0] mem_addr,
	output logic      [9:0] gp_addr
);
	wire logic [9:0] idx_merged;

	assign idx_merged = {index_pointer_high, index_pointer_mid, index_pointer_low};
	// the index is merged by OR, not added: carries never ripple across fields
	assign mem_addr = {bank, row, col} | (index_enable ? idx_merged : 10'h000);
	assign gp_addr  = {gp_row_pointer_high, gp_row_pointer_low, reg_col};
endmodule

// ===== src/nibble_add_datapath.sv
// nibble add datapath with data memory, system flags and register port
`timescale 1ns/1ps
`include "nibble_add_params.svh"

module nibble_add_datapath (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             busy,
	output logic             instr_done,
	output logic             illegal_op,
	output logic             carry_flag,
	output logic             zero_flag
);
	import nibble_add_pkg::*;

	logic [3:0]  mem_q [0:1023];

	state_t      state_q;
	state_t      state_d;
	op_t         op_q;
	op_t         op_dec;
	logic [2:0]  row_q;
	logic [3:0]  col_q;
	logic [3:0]  imm_q;
	logic        compare_flag_q;
	logic        decimal_mode_q;
	logic        index_enable_q;
	logic        carry_q;
	logic        zero_q;
	logic [2:0]  bank_q;
	logic [2:0]  index_pointer_high_q;
	logic [2:0]  index_pointer_mid_q;
	logic [3:0]  index_pointer_low_q;
	logic [2:0]  gp_row_pointer_high_q;
	logic [2:0]  gp_row_pointer_low_q;
	logic [3:0]  result_q;
	logic        ill_seen_q;
	logic [7:0]  rdata_q;
	logic        done_q;
	logic        ill_q;

	wire logic [4:0]  opcode;
	wire logic        take;
	wire logic        exec;
	wire mem_addr_t   eff_addr;
	wire mem_addr_t   gp_addr;
	wire logic [3:0]  mem_nib;
	wire logic [3:0]  reg_nib;
	wire logic [3:0]  opnd_a;
	wire logic [3:0]  opnd_b;
	wire logic        cin;
	wire logic [3:0]  sum;
	wire logic        cout;
	wire logic        core_we;
	wire mem_addr_t   core_addr;
	wire logic        zero_d;
	wire logic        mem_sel;
	wire logic        sw_mem_we;
	wire logic        sw_reg_we;
	wire logic [3:0]  ofs;
	wire logic [7:0]  reg_mux;
	wire logic [7:0]  rd_next;

	assign opcode = instr_word[`NA_OPC_HI:`NA_OPC_LO];
	assign op_dec = (opcode == `NA_OPC_ADD_IMM)  ? op_add_imm :
	                (opcode == `NA_OPC_CARRY_REG) ? op_carry_reg :
	                (opcode == `NA_OPC_CARRY_IMM) ? op_carry_imm : op_bad;
	// a request while busy is dropped; the sequencer waits on busy
	assign take = instr_valid && (state_q == st_idle);
	assign exec = (state_q == st_exec);

	addr_former u_addr (
		.bank                (bank_q),
		.row                 (row_q),
		.col                 (col_q),
		.index_enable        (index_enable_q),
		.index_pointer_high  (index_pointer_high_q),
		.index_pointer_mid   (index_pointer_mid_q),
		.index_pointer_low   (index_pointer_low_q),
		.gp_row_pointer_high (gp_row_pointer_high_q),
		.gp_row_pointer_low  (gp_row_pointer_low_q),
		.reg_col             (imm_q),
		.mem_addr            (eff_addr),
		.gp_addr             (gp_addr)
	);

	assign mem_nib = mem_q[eff_addr];
	assign reg_nib = mem_q[gp_addr];
	// register form: register plus memory; immediate forms: memory plus immediate
	assign opnd_a  = (op_q == op_carry_reg) ? reg_nib : mem_nib;
	assign opnd_b  = (op_q == op_carry_reg) ? mem_nib : imm_q;
	assign cin     = (op_q != op_add_imm) && carry_q;

	nibble_adder u_add (
		.a       (opnd_a),
		.b       (opnd_b),
		.cin     (cin),
		.decimal (decimal_mode_q),
		.sum     (sum),
		.cout    (cout)
	);

	assign core_we   = exec && !compare_flag_q;
	assign core_addr = (op_q == op_carry_reg) ? gp_addr : eff_addr;
	// a zero result while comparing leaves zero untouched for chained compares
	assign zero_d    = (sum != 4'h0) ? 1'b0 :
	                   compare_flag_q ? zero_q : 1'b1;

	assign mem_sel   = reg_addr[`NA_MEM_SEL_BIT];
	assign sw_mem_we = reg_wr && mem_sel;
	assign sw_reg_we = reg_wr && !mem_sel;
	assign ofs       = reg_addr[3:0];

	assign reg_mux =
		(ofs == `NA_OFS_CTRL)     ? {5'h00, index_enable_q, decimal_mode_q, compare_flag_q} :
		(ofs == `NA_OFS_FLAGS)    ? {6'h00, zero_q, carry_q} :
		(ofs == `NA_OFS_IDX_HIGH) ? {5'h00, index_pointer_high_q} :
		(ofs == `NA_OFS_IDX_MID)  ? {5'h00, index_pointer_mid_q} :
		(ofs == `NA_OFS_IDX_LOW)  ? {4'h0, index_pointer_low_q} :
		(ofs == `NA_OFS_GP_HIGH)  ? {5'h00, gp_row_pointer_high_q} :
		(ofs == `NA_OFS_GP_LOW)   ? {5'h00, gp_row_pointer_low_q} :
		(ofs == `NA_OFS_STATUS)   ? {2'h0, ill_seen_q, exec, result_q} :
		(ofs == `NA_OFS_BANK)     ? {5'h00, bank_q} : 8'h00;
	assign rd_next = !reg_rd ? 8'h00 :
	                 mem_sel ? {4'h0, mem_q[reg_addr[9:0]]} : reg_mux;

	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: begin
				if (take && (op_dec != op_bad))
					state_d = st_exec;
			end
			st_exec: state_d = st_idle;
			default: state_d = st_idle;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= st_idle;
			op_q    <= op_add_imm;
			row_q   <= 3'h0;
			col_q   <= `NA_NIB_RST;
			imm_q   <= `NA_NIB_RST;
		end else begin
			state_q <= state_d;
			if (take) begin
				op_q  <= op_dec;
				row_q <= instr_word[`NA_ROW_HI:`NA_ROW_LO];
				col_q <= instr_word[`NA_COL_HI:`NA_COL_LO];
				imm_q <= instr_word[`NA_IMM_HI:`NA_IMM_LO];
			end
		end
	end

	// the core write wins over a software write to memory in the same cycle
	always_ff @(posedge sys_clk) begin
		if (core_we)
			mem_q[core_addr] <= sum;
		if (sw_mem_we && !(core_we && (core_addr == reg_addr[9:0])))
			mem_q[reg_addr[9:0]] <= reg_wdata[3:0];
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_flag_q <= 1'b0;
			decimal_mode_q <= 1'b0;
			index_enable_q <= 1'b0;
		end else if (sw_reg_we && (ofs == `NA_OFS_CTRL)) begin
			compare_flag_q <= reg_wdata[`NA_CTRL_COMPARE];
			decimal_mode_q <= reg_wdata[`NA_CTRL_DEC];
			index_enable_q <= reg_wdata[`NA_CTRL_INDEX];
		end
	end

	// the addition's flag update wins over a software write in the same cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			carry_q <= 1'b0;
			zero_q  <= 1'b0;
		end else if (exec) begin
			carry_q <= cout;
			zero_q  <= zero_d;
		end else if (sw_reg_we && (ofs == `NA_OFS_FLAGS)) begin
			carry_q <= reg_wdata[`NA_FLAGS_CARRY];
			zero_q  <= reg_wdata[`NA_FLAGS_Z];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			index_pointer_high_q  <= 3'h0;
			index_pointer_mid_q   <= 3'h0;
			index_pointer_low_q   <= `NA_NIB_RST;
			gp_row_pointer_high_q <= 3'h0;
			gp_row_pointer_low_q  <= 3'h0;
			bank_q                <= 3'h0;
		end else if (sw_reg_we) begin
			if (ofs == `NA_OFS_IDX_HIGH)
				index_pointer_high_q <= reg_wdata[2:0];
			if (ofs == `NA_OFS_IDX_MID)
				index_pointer_mid_q <= reg_wdata[2:0];
			if (ofs == `NA_OFS_IDX_LOW)
				index_pointer_low_q <= reg_wdata[3:0];
			if (ofs == `NA_OFS_GP_HIGH)
				gp_row_pointer_high_q <= reg_wdata[2:0];
			if (ofs == `NA_OFS_GP_LOW)
				gp_row_pointer_low_q <= reg_wdata[2:0];
			if (ofs == `NA_OFS_BANK)
				bank_q <= reg_wdata[2:0];
		end
	end

	// illegal opcode is sticky until software writes the status register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			result_q   <= `NA_NIB_RST;
			ill_seen_q <= 1'b0;
			rdata_q    <= 8'h00;
			done_q     <= 1'b0;
			ill_q      <= 1'b0;
		end else begin
			rdata_q <= rd_next;
			done_q  <= exec;
			ill_q   <= take && (op_dec == op_bad);
			if (exec)
				result_q <= sum;
			if (take && (op_dec == op_bad))
				ill_seen_q <= 1'b1;
			else if (sw_reg_we && (ofs == `NA_OFS_STATUS))
				ill_seen_q <= 1'b0;
		end
	end

	assign reg_rdata  = rdata_q;
	assign busy       = exec;
	assign instr_done = done_q;
	assign illegal_op = ill_q;
	assign carry_flag = carry_q;
	assign zero_flag  = zero_q;

	sequence s_take_add_imm;
		take && (opcode == `NA_OPC_ADD_IMM);
	endsequence

	sequence s_exec_add_imm;
		exec && (op_q == op_add_imm);
	endsequence

	property p_decode_add_imm;
		@(posedge sys_clk) disable iff (!arst_n)
		s_take_add_imm |=> s_exec_add_imm ##1 instr_done;
	endproperty
	a_decode_add_imm: assert property (p_decode_add_imm)
		else $error("immediate add opcode not executed");

	property p_add_imm_writes;
		@(posedge sys_clk) disable iff (!arst_n)
		// binary only: a decimal sum is folded and is checked separately
		(s_exec_add_imm and !(compare_flag_q || decimal_mode_q)) |->
			core_we && (core_addr == eff_addr) && (sum == mem_nib + imm_q);
	endproperty
	a_add_imm_writes: assert property (p_add_imm_writes)
		else $error("immediate add did not write back sum");

	property p_cmp_no_write;
		@(posedge sys_clk) disable iff (!arst_n)
		compare_flag_q |-> !core_we;
	endproperty
	a_cmp_no_write: assert property (p_cmp_no_write)
		else $error("destination written while comparing");

	property p_carry_follows;
		@(posedge sys_clk) disable iff (!arst_n)
		exec |=> (carry_flag == $past(cout));
	endproperty
	a_carry_follows: assert property (p_carry_follows)
		else $error("carry flag does not follow carry out");

	property p_nonzero_clears;
		@(posedge sys_clk) disable iff (!arst_n)
		(exec && (sum != 4'h0)) |=> !zero_flag;
	endproperty
	a_nonzero_clears: assert property (p_nonzero_clears)
		else $error("zero flag not cleared on nonzero result");

	property p_zero_sets;
		@(posedge sys_clk) disable iff (!arst_n)
		(exec && (sum == 4'h0) && !compare_flag_q) |=> zero_flag;
	endproperty
	a_zero_sets: assert property (p_zero_sets)
		else $error("zero flag not set on zero result");

	property p_zero_holds;
		@(posedge sys_clk) disable iff (!arst_n)
		(exec && (sum == 4'h0) && compare_flag_q) |=> $stable(zero_flag);
	endproperty
	a_zero_holds: assert property (p_zero_holds)
		else $error("zero flag changed on zero compare");

	property p_decimal_fix;
		@(posedge sys_clk) disable iff (!arst_n)
		(exec && decimal_mode_q) |-> (sum <= 4'h9);
	endproperty
	a_decimal_fix: assert property (p_decimal_fix)
		else $error("decimal result above nine");

	property p_reg_form_target;
		@(posedge sys_clk) disable iff (!arst_n)
		(exec && (op_q == op_carry_reg) && !compare_flag_q) |->
			(core_addr == gp_addr) && (opnd_b == mem_nib);
	endproperty
	a_reg_form_target: assert property (p_reg_form_target)
		else $error("register form addressed wrong nibble");
endmodule

// ===== tb/nibble_seq_model.sv
// instruction sequencer model that holds a request until the datapath takes it
`timescale 1ns/1ps

module nibble_seq_model (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        req,
	input  wire logic [15:0] word,
	input  wire logic        busy,
	output logic             instr_valid,
	output logic      [15:0] instr_word
);
	// the request stands until an edge sees busy low; that edge takes it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_valid <= 1'b0;
			instr_word  <= 16'h0000;
		end else if (req && !instr_valid) begin
			instr_valid <= 1'b1;
			instr_word  <= word;
		end else if (instr_valid && !busy) begin
			instr_valid <= 1'b0;
			// a released word is garbled so a late sample cannot pass by luck
			instr_word  <= ~instr_word;
		end
	end
endmodule

// ===== tb/nibble_add_datapath_tb_top.sv
// self-checking bench for the nibble add datapath
`timescale 1ns/1ps

module nibble_add_datapath_tb_top;
	logic        sys_clk         = 1'b0;
	logic        arst_n          = 1'b0;
	logic        req             = 1'b0;
	logic [15:0] word            = 16'h0000;
	logic [11:0] reg_addr        = 12'h000;
	logic [7:0]  reg_wdata       = 8'h00;
	logic        reg_wr          = 1'b0;
	logic        reg_rd          = 1'b0;
	logic        instr_valid;
	logic [15:0] instr_word;
	logic [7:0]  reg_rdata;
	logic        busy;
	logic        instr_done;
	logic        illegal_op;
	logic        carry_flag;
	logic        zero_flag;
	int          errors          = 0;
	int          samples_checked = 0;

	always #5 sys_clk = ~sys_clk;

	nibble_seq_model u_nibble_seq_model (
		.sys_clk     (sys_clk),
		.arst_n      (arst_n),
		.req         (req),
		.word        (word),
		.busy        (busy),
		.instr_valid (instr_valid),
		.instr_word  (instr_word)
	);

	nibble_add_datapath u_nibble_add_datapath (
		.sys_clk     (sys_clk),
		.arst_n      (arst_n),
		.instr_valid (instr_valid),
		.instr_word  (instr_word),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.busy        (busy),
		.instr_done  (instr_done),
		.illegal_op  (illegal_op),
		.carry_flag  (carry_flag),
		.zero_flag   (zero_flag)
	);

	task automatic wrap_up();
		$display("checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		@(negedge sys_clk);
		chk($sformatf("read %h", a), exp, reg_rdata);
		@(negedge sys_clk);
		chk("read data after its cycle", 8'h00, reg_rdata);
	endtask

	// fl is {zero, carry} expected once the instruction has finished
	task automatic exec(input logic [15:0] w, input logic [1:0] fl, input logic ill);
		int   n;
		logic seen_busy;
		seen_busy = 1'b0;
		@(posedge sys_clk);
		req  <= 1'b1;
		word <= w;
		@(posedge sys_clk);
		req  <= 1'b0;
		for (n = 0; n < 8; n++) begin
			@(negedge sys_clk);
			if (busy === 1'b1)
				seen_busy = 1'b1;
			if (instr_done === 1'b1 || illegal_op === 1'b1)
				break;
		end
		chk("busy", {7'h00, ~ill}, {7'h00, seen_busy});
		chk("instr_done", {7'h00, ~ill}, {7'h00, instr_done});
		chk("illegal_op", {7'h00, ill}, {7'h00, illegal_op});
		chk("flags", {6'h00, fl}, {6'h00, zero_flag, carry_flag});
	endtask

	initial begin
		#200000;
		errors++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(12'h000, 8'h00);
		rd(12'h001, 8'h00);
		rd(12'h00F, 8'h00);
		// general registers sit in row 1 of bank 0
		wr(12'h006, 8'h01);
		wr(12'h82F, 8'h0B);
		exec(16'h82F5, 2'b11, 1'b0);
		rd(12'h82F, 8'h00);
		wr(12'h82E, 8'h03);
		exec(16'h92E4, 2'b00, 1'b0);
		rd(12'h82E, 8'h08);
		wr(12'h813, 8'h07);
		wr(12'h82D, 8'h09);
		wr(12'h001, 8'h01);
		exec(16'h12D3, 2'b01, 1'b0);
		rd(12'h813, 8'h01);
		rd(12'h82D, 8'h09);
		// compare mode: zero accumulates, destinations untouched
		wr(12'h000, 8'h01);
		wr(12'h001, 8'h00);
		exec(16'h82F0, 2'b00, 1'b0);
		wr(12'h001, 8'h02);
		exec(16'h82E8, 2'b11, 1'b0);
		rd(12'h82E, 8'h08);
		exec(16'h92E0, 2'b00, 1'b0);
		rd(12'h82E, 8'h08);
		exec(16'h12D3, 2'b00, 1'b0);
		rd(12'h813, 8'h01);
		// decimal mode, then a sum of exactly nine needs no correction
		wr(12'h000, 8'h02);
		wr(12'h82F, 8'h07);
		exec(16'h82F5, 2'b01, 1'b0);
		rd(12'h82F, 8'h02);
		exec(16'h92F6, 2'b00, 1'b0);
		rd(12'h82F, 8'h09);
		// index pointer 0.40 ORed into operand 0.2F
		wr(12'h000, 8'h04);
		wr(12'h003, 8'h04);
		wr(12'h86F, 8'h01);
		exec(16'h82F5, 2'b00, 1'b0);
		rd(12'h86F, 8'h06);
		rd(12'h82F, 8'h09);
		// binary mode in bank 1 gives no decimal carry
		wr(12'h000, 8'h00);
		wr(12'h008, 8'h01);
		wr(12'h8AF, 8'h07);
		exec(16'h82F5, 2'b00, 1'b0);
		rd(12'h8AF, 8'h0C);
		exec(16'hF800, 2'b00, 1'b1);
		// status: sticky illegal mark over the last result, cleared by a write
		rd(12'h007, 8'h2C);
		wr(12'h007, 8'h00);
		rd(12'h007, 8'h0C);
		wrap_up();
	end
endmodule
